// ### pkg/sls_pkg.sv
`default_nettype none
package sls_pkg;
	// clock and conversion band
	localparam int unsigned CLK_MHZ     = 125; // clk_i rate in MHz
	localparam int unsigned FS_MIN_MSPS = 40;  // slowest conversion rate
	localparam int unsigned FS_MAX_MSPS = 250; // fastest, upper speed grade
	localparam int unsigned FS_170_MSPS = 170; // fastest, lower speed grade
	localparam int unsigned DIV_MIN     = 2;   // smallest integer ratio
	localparam int unsigned DIV_MAX     = 8;   // largest integer ratio
	// lane framing
	localparam int unsigned UI_PER_CONV   = 20; // bit periods per conversion
	localparam int unsigned FRAMES_PER_MF = 32; // frames in one multiframe
	localparam int unsigned SC0_WAIT_MF   = 5;  // sync fall to first K
	localparam int unsigned SC1_WAIT_MF   = 6;  // sysref rise to first K
	localparam int unsigned CGS_MIN_MF    = 1;  // least K phase length
	localparam logic [7:0]  SC0_WAIT_TICKS = 8'(SC0_WAIT_MF * FRAMES_PER_MF);
	localparam logic [7:0]  SC1_WAIT_TICKS = 8'(SC1_WAIT_MF * FRAMES_PER_MF);
	localparam logic [7:0]  CGS_TICKS      = 8'(CGS_MIN_MF * FRAMES_PER_MF);
	localparam logic [4:0]  FRAME_LAST     = 5'(FRAMES_PER_MF - 1);
	localparam logic [7:0]  K28_5          = 8'hbc; // comma symbol
	// latencies in conversion cycles
	localparam int unsigned DATA_LAT  = 36; // sample in to lane word
	localparam int unsigned FD_LAT    = 7;  // threshold detect delay
	localparam logic [1:0]  OVR_RECOV = 2'h3; // out-of-range recovery
	// wake-up times
	localparam int unsigned CORE_PD_WAKE_US = 250;
	localparam int unsigned STBY_WAKE_US    = 10;
	localparam int unsigned OUT_PD_WAKE_US  = 50;
	localparam int unsigned CORE_PD_WAKE_CYC_DEF = CORE_PD_WAKE_US * CLK_MHZ;
	localparam int unsigned OUT_PD_WAKE_CYC_DEF  = OUT_PD_WAKE_US * CLK_MHZ;
	localparam logic [15:0] STBY_WAKE_CYC = 16'(STBY_WAKE_US * CLK_MHZ);
	// widths and buffer
	localparam int unsigned SAMPLE_W   = 14;
	localparam int unsigned LANE_W     = 18; // two k flags, two octets
	localparam int unsigned FIFO_DEPTH = 32;
	// register offsets and fields
	localparam logic [7:0] REG_CTRL      = 8'h00;
	localparam logic [7:0] REG_THRESH    = 8'h04;
	localparam logic [7:0] REG_STATUS    = 8'h08;
	localparam int unsigned CTRL_SC_BIT  = 0;
	localparam int unsigned CTRL_DIV_LSB = 4;
	localparam int unsigned CTRL_DCS_BIT = 7;
	localparam int unsigned CTRL_PWR_LSB = 8;
	localparam int unsigned STAT_CORE_BIT = 2;
	localparam int unsigned STAT_OUT_BIT  = 3;
	localparam int unsigned STAT_OVF_BIT  = 4;
	localparam int unsigned STAT_RATE_BIT = 5;
	// reset values
	localparam logic        RST_SUBCLASS = 1'b1;
	localparam logic [2:0]  RST_DIV      = 3'h1;
	localparam logic        RST_DCS      = 1'b1;
	localparam logic [13:0] RST_THRESH   = 14'h1000;
	typedef enum logic [1:0] {
		PWR_ON = 2'b00, PWR_STBY = 2'b01, PWR_FULL = 2'b10, PWR_OUT = 2'b11
	} sls_pwr_e;
	typedef enum logic [1:0] {
		LNK_IDLE = 2'b00, LNK_WAIT = 2'b01, LNK_CGS = 2'b10, LNK_DATA = 2'b11
	} sls_lnk_e;
endpackage : sls_pkg
`default_nettype wire

// ### pkg/sls_stream_if.sv
`default_nettype none
interface sls_stream_if #(parameter int unsigned W = 18);
	logic         wr_valid; // word offered
	logic         wr_ready; // buffer has room
	logic [W-1:0] wr_data;  // offered word
	logic         rd_valid; // head word present
	logic         rd_ready; // drain takes head
	logic [W-1:0] rd_data;  // head word
	modport fill  (output wr_valid, wr_data, input wr_ready);
	modport store (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data);
	modport drain (input rd_valid, rd_data, output rd_ready);
endinterface : sls_stream_if
`default_nettype wire

// ### verilog/sls_fifo.sv
`default_nettype none
module sls_fifo #(
	parameter int unsigned W     = 18, // word width
	parameter int unsigned DEPTH = 32  // words of storage
)(
	input  wire logic clk_i, // clock
	input  wire logic rst_i, // sync reset
	sls_stream_if.store s    // both sides
);
	localparam int unsigned AW = $clog2(DEPTH);
	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem; // storage
		logic [AW-1:0]           wp;  // write index
		logic [AW-1:0]           rp;  // read index
		logic [AW:0]             cnt; // words in storage
		logic                    ov;  // output register full
		logic [W-1:0]            od;  // output register
	} sls_fifo_s;
	sls_fifo_s q, n;
	logic push, pop;
	// full is honest: the head register adds one more slot of slack
	assign s.wr_ready = (q.cnt != (AW + 1)'(DEPTH));
	assign s.rd_valid = q.ov;
	assign s.rd_data  = q.od;
	assign push = s.wr_valid && s.wr_ready;
	assign pop  = (q.cnt != '0) && (!q.ov || s.rd_ready);
	// next state
	always_comb
	begin
		n = q;
		if (push)
		begin
			n.mem[q.wp] = s.wr_data;
			n.wp = q.wp + 1'b1;
		end
		if (pop)
		begin
			n.od = q.mem[q.rp];
			n.ov = 1'b1;
			n.rp = q.rp + 1'b1;
		end
		else if (s.rd_ready)
			n.ov = 1'b0; // head consumed, nothing behind it
		if (push && !pop)
			n.cnt = q.cnt + 1'b1;
		else if (pop && !push)
			n.cnt = q.cnt - 1'b1;
	end
	// state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			q <= '0;
		else
			q <= n;
	end
endmodule : sls_fifo
`default_nettype wire

// ### verilog/sls_clkdiv.sv
`default_nettype none
module sls_clkdiv
	import sls_pkg::*;
(
	input  wire logic       clk_i,   // input clock
	input  wire logic       rst_i,   // sync reset
	input  wire logic [2:0] ratio_i, // divide ratio minus one
	input  wire logic       dcs_i,   // duty cycle stabilizer
	output logic            tick_o,  // one conversion strobe
	output logic            clk_o    // divided clock level
);
	typedef struct packed {
		logic [2:0] cnt;  // phase within period
		logic       tick; // conversion strobe
		logic       lvl;  // divided clock
	} sls_div_s;
	sls_div_s q, n;
	// >= so a shrinking ratio never leaves the counter stranded
	always_comb
	begin
		n = q;
		n.cnt  = (q.cnt >= ratio_i) ? 3'h0 : q.cnt + 3'h1;
		n.tick = (q.cnt >= ratio_i);
		// stabilizer gives half duty; without it a short high pulse
		n.lvl  = dcs_i ? (n.cnt <= (ratio_i >> 1)) : (n.cnt == 3'h0);
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			q <= '0;
		else
			q <= n;
	end
	assign tick_o = q.tick;
	assign clk_o  = q.lvl;
	property p_div_pass;
		@(posedge clk_i) disable iff (rst_i)
		(ratio_i == 3'h0 && $past(ratio_i) == 3'h0 && !$past(rst_i)) |-> tick_o;
	endproperty
	a_div_pass: assert property (p_div_pass) else $error("pass-through lost a tick");
	property p_div_gap;
		@(posedge clk_i) disable iff (rst_i)
		(tick_o && ratio_i != 3'h0) |=> !tick_o;
	endproperty
	a_div_gap: assert property (p_div_gap) else $error("divided ticks too close");
endmodule : sls_clkdiv
`default_nettype wire

// ### verilog/sls_link_top.sv
// Added by the designer: the register offsets and register access over Wishbone.
`default_nettype none
module sls_link_top
	import sls_pkg::*;
#(
	parameter int unsigned CORE_PD_WAKE_CYC = CORE_PD_WAKE_CYC_DEF, // full power-down wake
	parameter int unsigned OUT_PD_WAKE_CYC  = OUT_PD_WAKE_CYC_DEF   // lane power-down wake
)(
	input  wire logic          clk_i,                   // input clock
	input  wire logic          rst_i,                   // sync reset, high
	input  wire logic          wb_cyc_i,                // bus cycle
	input  wire logic          wb_stb_i,                // bus strobe
	input  wire logic          wb_we_i,                 // write enable
	input  wire logic [7:0]    wb_adr_i,                // byte address
	input  wire logic [3:0]    wb_sel_i,                // byte enables
	input  wire logic [31:0]   wb_dat_i,                // write data
	output logic      [31:0]   wb_dat_o,                // read data
	output logic               wb_ack_o,                // acknowledge
	input  wire logic [13:0]   sample_i,                // core sample, signed
	input  wire logic          sync_request_in_n_i,     // receiver sync request
	input  wire logic          sysref_i,                // system reference pin
	output logic      [15:0]   lane_data_o,             // two octets
	output logic      [1:0]    lane_k_o,                // control flags
	output logic               lane_valid_o,            // lane word present
	input  wire logic          lane_ready_i,            // serializer takes word
	output logic               threshold_detect_flag_o, // level exceeded
	output logic               conv_clk_o               // divided clock
);
	typedef struct packed {
		logic                              subclass;  // 1: sysref aligned
		logic [2:0]                        div;       // ratio minus one
		logic                              duty_cycle_stabilizer;       // stabilizer enable
		sls_pwr_e                          pwr;       // power mode
		logic [13:0]                       thresh;    // detect level
		logic                              ovf;       // sticky lane drop
		logic                              ack;       // bus answer
		logic [31:0]                       dat;       // bus read data
		logic                              sync_s1;   // meta stage
		logic                              sync_s2;   // safe sync level
		logic                              sref_s1;   // meta stage
		logic                              sref_s2;   // safe sysref
		logic                              sref_d;    // for edge
		logic                              sref_pend; // edge awaiting tick
		sls_lnk_e                          lnk;       // link phase
		logic [7:0]                        wcnt;      // phase tick count
		logic [4:0]                        fcnt;      // frame in multiframe
		logic [DATA_LAT-1:0][SAMPLE_W-1:0] ring;      // sample delay
		logic [5:0]                        ridx;      // ring index
		logic [FD_LAT-1:0]                 fdpipe;    // detect delay
		logic [1:0]                        recov;     // recovery hold
		logic                              fd;        // detect flag
		logic [15:0]                       core_cnt;  // core wake count
		logic [15:0]                       out_cnt;   // lane wake count
		logic                              rate_bad;  // rate out of band
	} sls_top_s;
	sls_top_s q, n;

	localparam logic [15:0] CORE_CYC = 16'(CORE_PD_WAKE_CYC);
	localparam logic [15:0] OUT_CYC  = 16'(OUT_PD_WAKE_CYC);

	logic        div_tick;   // one per conversion
	logic        core_ready; // samples meaningful
	logic        out_ready;  // lane powered and in band
	logic        emit;       // phase sends words
	logic        adv;        // tick not stalled
	logic        det;        // sample over level
	logic        hit;        // bus request taken
	logic [31:0] ctrl_word;  // control as read
	logic [31:0] stat_word;  // status as read
	logic [31:0] cw;         // merged control write
	logic [31:0] tw;         // merged threshold write
	logic [7:0]  wait_tgt;   // ticks before K

	sls_stream_if #(.W(LANE_W)) strm ();

	// byte-enable merge, used for the control and threshold registers
	function automatic logic [31:0] wmerge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  sel
	);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++)
			if (sel[i]) r[8*i +: 8] = new_v[8*i +: 8];
		return r;
	endfunction : wmerge

	// conversion rate is clk/(d+1); outside the band the link stays idle
	function automatic logic rate_ok(input logic [2:0] d);
		int unsigned r;
		r = 32'(d) + 32'd1;
		return (r * FS_MIN_MSPS <= CLK_MHZ) && (CLK_MHZ <= r * FS_MAX_MSPS);
	endfunction : rate_ok

	// saturating decrement for wake counters
	function automatic logic [15:0] dec(input logic [15:0] v);
		return (v == 16'h0) ? 16'h0 : v - 16'h1;
	endfunction : dec

	// signed sample magnitude
	function automatic logic [13:0] mag(input logic [13:0] s);
		return s[13] ? 14'(~s + 14'h1) : s;
	endfunction : mag

	// conversion strobe from the integer divider
	sls_clkdiv u_div (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.ratio_i (q.div),
		.dcs_i   (q.duty_cycle_stabilizer),
		.tick_o  (div_tick),
		.clk_o   (conv_clk_o)
	);

	// lane words wait here for the serializer
	sls_fifo #(.W(LANE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.s     (strm.store)
	);

	// register views
	assign ctrl_word = {22'h0, q.pwr, q.duty_cycle_stabilizer, q.div, 3'h0, q.subclass};
	assign stat_word = {26'h0, q.rate_bad, q.ovf, out_ready, core_ready, q.lnk};

	// power state decode
	assign core_ready = (q.pwr == PWR_ON || q.pwr == PWR_OUT) && q.core_cnt == 16'h0;
	assign out_ready  = (q.pwr == PWR_ON || q.pwr == PWR_STBY) && q.out_cnt == 16'h0
		&& rate_ok(q.div);

	// link stream side
	assign emit     = (q.lnk == LNK_CGS) || (q.lnk == LNK_DATA);
	assign adv      = div_tick && (!emit || strm.wr_ready); // full buffer stalls link
	assign wait_tgt = q.subclass ? SC1_WAIT_TICKS : SC0_WAIT_TICKS;
	assign det      = core_ready && (mag(sample_i) > q.thresh);
	assign hit      = wb_cyc_i && wb_stb_i && !q.ack;

	// one word per conversion: two octets, twenty bit periods once coded
	assign strm.wr_valid = div_tick && emit;
	assign strm.wr_data  = (q.lnk == LNK_CGS) ? {2'b11, K28_5, K28_5}
		: {2'b00, q.ring[q.ridx], 2'b00};
	assign strm.rd_ready = lane_ready_i;

	// next state
	always_comb
	begin
		n  = q;
		cw = wmerge(ctrl_word, wb_dat_i, wb_sel_i);
		tw = wmerge({18'h0, q.thresh}, wb_dat_i, wb_sel_i);
		// pins pass two flops before use
		n.sync_s1 = sync_request_in_n_i;
		n.sync_s2 = q.sync_s1;
		n.sref_s1 = sysref_i;
		n.sref_s2 = q.sref_s1;
		n.sref_d  = q.sref_s2;
		n.rate_bad = !rate_ok(q.div);

		// bus slave: answer one cycle after the request is seen
		n.ack = hit;
		if (hit && wb_we_i)
		begin
			case (wb_adr_i)
				REG_CTRL:
				begin
					n.subclass = cw[CTRL_SC_BIT];
					n.div      = cw[CTRL_DIV_LSB +: 3];
					n.duty_cycle_stabilizer      = cw[CTRL_DCS_BIT];
					n.pwr      = sls_pwr_e'(cw[CTRL_PWR_LSB +: 2]);
				end
				REG_THRESH:
					n.thresh = tw[13:0];
				REG_STATUS:
					if (wb_sel_i[0] && wb_dat_i[STAT_OVF_BIT])
						n.ovf = 1'b0; // write one to clear
				default: ; // unmapped writes ignored
			endcase
		end
		if (hit && !wb_we_i)
		begin
			case (wb_adr_i)
				REG_CTRL:   n.dat = ctrl_word;
				REG_THRESH: n.dat = {18'h0, q.thresh};
				REG_STATUS: n.dat = stat_word;
				default:    n.dat = 32'h0; // unmapped reads zero
			endcase
		end

		// wake counters load while asleep and run down once awake
		case (q.pwr)
			PWR_FULL:
			begin
				n.core_cnt = CORE_CYC;
				n.out_cnt  = OUT_CYC;
			end
			PWR_STBY:
			begin
				// a core still waking from full power-down keeps its longer count
				if (q.core_cnt < STBY_WAKE_CYC)
					n.core_cnt = STBY_WAKE_CYC;
				n.out_cnt = dec(q.out_cnt);
			end
			PWR_OUT:
			begin
				n.out_cnt  = OUT_CYC;
				n.core_cnt = dec(q.core_cnt);
			end
			default:
			begin
				n.core_cnt = dec(q.core_cnt);
				n.out_cnt  = dec(q.out_cnt);
			end
		endcase

		// sample delay and detect pipeline run every conversion
		if (div_tick)
		begin
			n.ring[q.ridx] = core_ready ? sample_i : 14'h0;
			n.ridx   = (q.ridx == 6'(DATA_LAT - 1)) ? 6'h0 : q.ridx + 6'h1;
			n.fdpipe = {q.fdpipe[FD_LAT-2:0], det};
			if (q.fdpipe[FD_LAT-1])
				n.recov = OVR_RECOV;
			else if (q.recov != 2'h0)
				n.recov = q.recov - 2'h1;
		end
		n.fd = n.fdpipe[FD_LAT-1] || (n.recov != 2'h0);

		// link phases; a powered-down or out-of-band lane falls back to idle
		if (!out_ready)
		begin
			n.lnk  = LNK_IDLE;
			n.wcnt = 8'h0;
		end
		else if (adv)
		begin
			n.fcnt = (q.fcnt == FRAME_LAST) ? 5'h0 : q.fcnt + 5'h1;
			case (q.lnk)
				LNK_IDLE:
				begin
					n.wcnt = 8'h0;
					if (!q.subclass && !q.sync_s2)
						n.lnk = LNK_WAIT;
					else if (q.subclass && q.sref_pend)
					begin
						n.lnk       = LNK_WAIT;
						n.fcnt      = 5'h0;     // multiframe aligned to sysref
						n.sref_pend = 1'b0;
					end
				end
				LNK_WAIT:
				begin
					// first K goes out on the tick after the full wait
					if (q.wcnt == wait_tgt - 8'h1)
					begin
						n.lnk  = LNK_CGS;
						n.wcnt = 8'h0;
					end
					else
						n.wcnt = q.wcnt + 8'h1;
				end
				LNK_CGS:
				begin
					// leave only at a multiframe end, after one multiframe of K,
					// and only once the receiver has let go of its request
					if (q.wcnt >= CGS_TICKS - 8'h1 && q.sync_s2 && q.fcnt == FRAME_LAST)
						n.lnk = LNK_DATA;
					if (q.wcnt != 8'hff)
						n.wcnt = q.wcnt + 8'h1;
				end
				LNK_DATA:
					if (!q.sync_s2)
						n.lnk = LNK_IDLE; // resync request
				default:
					n.lnk = LNK_IDLE;
			endcase
		end
		// events are applied last so they win over a clear in the same cycle
		if (q.sref_s2 && !q.sref_d)
			n.sref_pend = 1'b1;
		if (div_tick && emit && !strm.wr_ready)
			n.ovf = 1'b1;
	end

	// state register
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			q          <= '0;
			q.subclass <= RST_SUBCLASS;
			q.div      <= RST_DIV;
			q.duty_cycle_stabilizer      <= RST_DCS;
			q.thresh   <= RST_THRESH;
			q.sync_s1  <= 1'b1; // idle: no request
			q.sync_s2  <= 1'b1;
		end
		else
			q <= n;
	end

	// outputs
	assign wb_ack_o                = q.ack;
	assign wb_dat_o                = q.dat;
	assign threshold_detect_flag_o = q.fd;
	assign lane_valid_o            = strm.rd_valid;
	assign lane_k_o                = strm.rd_data[17:16];
	assign lane_data_o             = strm.rd_data[15:0];

	// checks
	property p_rate_band;
		@(posedge clk_i) disable iff (rst_i)
		!rate_ok(q.div) |=> (q.lnk == LNK_IDLE);
	endproperty
	a_rate_band: assert property (p_rate_band) else $error("link ran out of band");
	property p_one_word;
		@(posedge clk_i) disable iff (rst_i)
		(strm.wr_valid && strm.wr_ready && q.div != 3'h0) |=> !strm.wr_valid;
	endproperty
	a_one_word: assert property (p_one_word) else $error("two words in one conversion");
	property p_sc0_wait;
		@(posedge clk_i) disable iff (rst_i)
		(q.lnk == LNK_CGS && $past(q.lnk) == LNK_WAIT && !$past(q.subclass))
			|-> $past(q.wcnt) == SC0_WAIT_TICKS - 8'h1;
	endproperty
	a_sc0_wait: assert property (p_sc0_wait) else $error("subclass 0 K too early");
	property p_sc1_wait;
		@(posedge clk_i) disable iff (rst_i)
		(q.lnk == LNK_CGS && $past(q.lnk) == LNK_WAIT && $past(q.subclass))
			|-> $past(q.wcnt) == SC1_WAIT_TICKS - 8'h1;
	endproperty
	a_sc1_wait: assert property (p_sc1_wait) else $error("subclass 1 K too early");
	property p_cgs_len;
		@(posedge clk_i) disable iff (rst_i)
		(q.lnk == LNK_DATA && $past(q.lnk) == LNK_CGS) |-> $past(q.wcnt) >= CGS_TICKS - 8'h1;
	endproperty
	a_cgs_len: assert property (p_cgs_len) else $error("K phase too short");
	property p_sync_hold;
		@(posedge clk_i) disable iff (rst_i)
		(q.lnk == LNK_CGS && !q.sync_s2) |=> (q.lnk != LNK_DATA);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("data under sync request");
	property p_ring_wrap;
		@(posedge clk_i) disable iff (rst_i)
		(div_tick && q.ridx == 6'(DATA_LAT - 1)) |=> (q.ridx == 6'h0);
	endproperty
	a_ring_wrap: assert property (p_ring_wrap) else $error("data delay not 36");
	property p_fd_recov;
		@(posedge clk_i) disable iff (rst_i)
		(div_tick && q.fdpipe[FD_LAT-1]) |=> (q.recov == OVR_RECOV && q.fd);
	endproperty
	a_fd_recov: assert property (p_fd_recov) else $error("detect hold wrong");
	property p_core_wake;
		@(posedge clk_i) disable iff (rst_i)
		(q.pwr == PWR_FULL) |=> (q.core_cnt == CORE_CYC && !core_ready);
	endproperty
	a_core_wake: assert property (p_core_wake) else $error("core wake not loaded");
	property p_stby_wake;
		@(posedge clk_i) disable iff (rst_i)
		(q.pwr == PWR_STBY && q.core_cnt < STBY_WAKE_CYC) |=> (q.core_cnt == STBY_WAKE_CYC);
	endproperty
	a_stby_wake: assert property (p_stby_wake) else $error("standby wake not loaded");
	property p_out_wake;
		@(posedge clk_i) disable iff (rst_i)
		(q.pwr == PWR_OUT) |=> (q.out_cnt == OUT_CYC && q.lnk == LNK_IDLE);
	endproperty
	a_out_wake: assert property (p_out_wake) else $error("lane wake not loaded");
endmodule : sls_link_top
`default_nettype wire

// ### tb/sls_rx_model.sv
`default_nettype none
// receiver side: sync request, reference pulse, lane back-pressure
module sls_rx_model
	import sls_pkg::*;
#(
	parameter int unsigned TICK_CLKS = 2 // clocks per conversion
)(
	input  wire logic clk_i,               // clock
	output logic      sync_request_in_n_o, // sync request, low
	output logic      sysref_o,            // reference pulse
	output logic      lane_ready_o         // takes lane word
);
	timeunit 1ns;
	timeprecision 1ps;
	int age  = 0; // clocks since reference fell
	int mode = 0; // 0 prompt, 1 every other clock, 2 stalled
	initial
	begin
		sync_request_in_n_o = 1'b0; // ask for sync from the start
		sysref_o = 1'b0;
		lane_ready_o = 1'b1;
	end
	// age counts from the fall, which is stricter than from the rise
	always @(posedge clk_i)
	begin
		age <= sysref_o ? 0 : age + 1;
		lane_ready_o <= (mode == 0) || (mode == 1 && !lane_ready_o);
	end
	task automatic set_mode(input int m);
		@(posedge clk_i);
		mode <= m;
	endtask : set_mode
	task automatic pulse_ref();
		@(posedge clk_i);
		sysref_o <= 1'b1;
		repeat (4) @(posedge clk_i);
		sysref_o <= 1'b0;
	endtask : pulse_ref
	task automatic drop_sync();
		@(posedge clk_i);
		sync_request_in_n_o <= 1'b0;
	endtask : drop_sync
	// release only once six multiframes of reference have passed
	task automatic release_sync();
		@(posedge clk_i);
		while (age < SC1_WAIT_MF * FRAMES_PER_MF * TICK_CLKS) @(posedge clk_i);
		sync_request_in_n_o <= 1'b1;
	endtask : release_sync
endmodule : sls_rx_model
`default_nettype wire

// ### tb/sls_link_top_tb_top.sv
`default_nettype none
module sls_link_top_tb_top
	import sls_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 0, stb = 0, we = 0, hold_s = 0;
	logic        ack, rdy, vld, sync_n, sref, fd, cclk;
	logic [7:0]  adr = 0;
	logic [3:0]  sel = 0;
	logic [31:0] wdat = 0, rdat, xs = 32'h2e89dd86;
	logic [13:0] smp = 0, s_val = 0, thr;
	logic [15:0] ldat, last_d;
	logic [1:0]  lk;
	logic [63:0] exp_q[$], e_w;
	int fails = 0, num_checks = 0, cyc_n = 0, kcnt = 0, dcnt = 0;
	int kb, kd, dk, first_k, t0, arm = 0, seen_k = 0, seen_d = 0;
	int wk[3] = '{30, 60, 1300};       // wake wait per power mode
	logic [1:0] pw[3] = '{3, 2, 1};    // lane pd, full pd, standby
	logic [31:0] bm[3] = '{8, 4, 4};   // ready bit watched per mode
	always #4 clk_i = ~clk_i;
	// short wake counts keep the run brief
	sls_link_top #(.CORE_PD_WAKE_CYC(40), .OUT_PD_WAKE_CYC(20)) dut_u (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.sample_i(smp), .sync_request_in_n_i(sync_n), .sysref_i(sref), .lane_data_o(ldat),
		.lane_k_o(lk), .lane_valid_o(vld), .lane_ready_i(rdy),
		.threshold_detect_flag_o(fd), .conv_clk_o(cclk));
	sls_rx_model #(.TICK_CLKS(2)) p_u (.clk_i(clk_i), .sync_request_in_n_o(sync_n),
		.sysref_o(sref), .lane_ready_o(rdy));
	function automatic logic [31:0] xorshift(input logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		return v ^ (v << 5);
	endfunction : xorshift
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : tally_and_finish
	// one classic cycle; read notes carry the mask of bits compared
	// no local limit: a missing ack is left to the run's own timeout
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [31:0] m);
		exp_q.push_back({w ? 32'h0 : m, d});
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		sel  <= s;
		do @(posedge clk_i); while (ack !== 1'b1);
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask : wb
	task automatic clks(input int n);
		repeat (n) @(posedge clk_i);
	endtask : clks
	// random samples, lane watcher, hang guard
	always @(posedge clk_i)
	begin
		cyc_n <= cyc_n + 1;
		xs <= xorshift(xs);
		smp <= hold_s ? s_val : xs[13:0];
		if (vld === 1'b1 && rdy === 1'b1 && lk === 2'b11)
		begin
			kcnt <= kcnt + 1;
			if (seen_k != arm)
				{first_k, kb, dk, seen_k} <= {cyc_n, kcnt, dcnt, arm};
		end
		else if (vld === 1'b1 && rdy === 1'b1)
		begin
			{dcnt, last_d} <= {dcnt + 1, ldat};
			if (seen_k == arm && seen_d != arm)
				{kd, seen_d} <= {kcnt, arm};
		end
		if (cyc_n > 20000)
		begin
			fails++;
			tally_and_finish();
		end
	end
	// oldest bus note against each acknowledged answer
	always @(posedge clk_i)
		if (ack === 1'b1 && exp_q.size() > 0)
		begin
			e_w = exp_q.pop_front();
			if (e_w[63:32] != 0)
				chk("wb_dat_o", e_w[31:0] & e_w[63:32], rdat & e_w[63:32]);
		end
	initial
	begin
		clks(10);
		rst_i <= 1'b0;
		// subclass 1, ratio field 1 at bits 6:4, stabilizer on
		wb(0, REG_CTRL, 32'h91, 4'hf, '1);
		wb(0, REG_THRESH, 32'h1000, 4'hf, '1);
		wb(0, 8'h0c, 0, 4'hf, '1);
		wb(0, REG_STATUS, 32'hc, 4'hf, 32'hc);
		thr = {2'b00, xs[11:0]} | 14'h0100;
		wb(1, REG_THRESH, {18'h0, thr}, 4'h3, 0);
		wb(0, REG_THRESH, {18'h0, thr}, 4'hf, '1);
		// subclass 1 bring-up, receiver slow
		p_u.set_mode(1);
		arm++;
		t0 = cyc_n + 1;
		p_u.pulse_ref();
		clks(500);
		chk("k_seen", arm, seen_k);
		chk("data_in_k", dk, dcnt);
		chk("k_wait", 1, first_k - t0 >= 2 * SC1_WAIT_TICKS);
		p_u.release_sync();
		clks(300);
		chk("k_len", 1, kd - kb >= 32);
		// threshold detect and sample path
		hold_s <= 1'b1;
		s_val <= 0;
		clks(80);
		chk("fd_low", 0, fd);
		s_val <= thr + 14'h0400;
		clks(10);
		chk("fd_early", 0, fd);
		clks(100);
		chk("fd_high", 1, fd);
		chk("lane_word", {thr + 14'h0400, 2'b00}, last_d);
		s_val <= 0;
		clks(40);
		chk("fd_clear", 0, fd);
		hold_s <= 1'b0;
		// buffer filled with receiver stalled, then sticky flag cleared
		p_u.set_mode(2);
		clks(150);
		chk("held_word", 1, vld);
		wb(0, REG_STATUS, 32'h10, 4'hf, 32'h10);
		p_u.set_mode(0);
		clks(20);
		wb(1, REG_STATUS, 32'h10, 4'h1, 0);
		wb(0, REG_STATUS, 0, 4'hf, 32'h10);
		// subclass 0 re-sync from data phase, divider in pass-through
		wb(1, REG_CTRL, 32'h80, 4'h1, 0);
		arm++;
		t0 = cyc_n + 1;
		p_u.drop_sync();
		clks(600);
		chk("k_seen0", arm, seen_k);
		chk("data_in_k0", dk, dcnt);
		chk("k_wait0", 1, first_k - t0 >= SC0_WAIT_TICKS);
		p_u.release_sync();
		clks(300);
		chk("k_len0", 1, kd - kb >= 32);
		// power modes; lane must drain empty in lane power-down
		for (int i = 0; i < 3; i++)
		begin
			wb(1, REG_CTRL, {22'h0, pw[i], 8'h80}, 4'h3, 0);
			wb(0, REG_STATUS, 0, 4'hf, bm[i]);
			clks(100);
			if (i == 0)
				chk("lane_drained", 0, vld);
			wb(1, REG_CTRL, 32'h80, 4'h3, 0);
			clks(wk[i]);
			wb(0, REG_STATUS, bm[i], 4'hf, bm[i]);
		end
		// every integer ratio from 2 to 8 and the rate band
		for (int d = 1; d < 8; d++)
		begin
			// stabilizer alternates so the period is measured with both duty shapes
			wb(1, REG_CTRL, {24'h0, d[0], 3'(d), 4'h0}, 4'h1, 0);
			clks(20);
			while (cclk !== 1'b0) @(posedge clk_i);
			while (cclk !== 1'b1) @(posedge clk_i);
			t0 = cyc_n;
			do @(posedge clk_i); while (cclk !== 1'b0);
			do @(posedge clk_i); while (cclk !== 1'b1);
			chk("conv_period", d + 1, cyc_n - t0);
			wb(0, REG_STATUS, (d >= 3) ? 32'h20 : 0, 4'hf, 32'h20);
		end
		tally_and_finish();
	end
endmodule : sls_link_top_tb_top
`default_nettype wire
